// *** hdl/prdc_top.sv ***
`timescale 1ns/100ps
module prdc_top #(
	parameter int COUNT_W = prdc_pkg::COUNT_WIDTH
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// PWM source from the period timer
	input  wire logic       pwm_in,
	input  wire logic       period_start,
	// Shutdown sources
	input  wire logic       cmp1_out,
	input  wire logic       cmp2_out,
	input  wire logic       int_pin_n,
	// Half-bridge outputs, pair AC carries the primary, BD the complement
	output logic            out_ac,
	output logic            out_ac_oe,
	output logic            out_bd,
	output logic            out_bd_oe,
	// Interrupt
	output logic            irq
);
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HALT = 2'b10
	} prdc_state_t;

	logic [7:0]  ctrl_r;
	logic [7:0]  shdn_r;
	logic [1:0]  irq_stat_r;
	logic [1:0]  irq_en_r;
	logic [7:0]  rdata_r;
	prdc_state_t state_r;
	logic        shdn_level;
	logic        halted;
	logic        db_ac;
	logic        db_bd;
	logic [2:0]  src;
	logic        wr_ctrl;
	logic        wr_shdn;
	logic        hw_clear;
	logic        halt_req;
	logic        resume;
	logic        wr_irq_en;
	logic        wr_irq_clr;
	logic [1:0]  irq_set;
	logic [1:0]  irq_clr;
	logic        pwm_ac;
	logic        pwm_bd;
	logic [COUNT_W-1:0] db_count;

	initial begin
		if (COUNT_W != prdc_pkg::COUNT_WIDTH) $error("prdc_top: COUNT_W must match the control field");
		if (prdc_pkg::CTRL_COUNT_MSB - prdc_pkg::CTRL_COUNT_LSB + 1 != COUNT_W) $error("prdc_top: count field width");
		if (prdc_pkg::IRQ_WIDTH != 2) $error("prdc_top: interrupt layout holds two events");
	end

	assign src        = shdn_r[prdc_pkg::SHDN_SRC_MSB:prdc_pkg::SHDN_SRC_LSB];
	assign wr_ctrl    = reg_wr && reg_addr == prdc_pkg::ADDR_CTRL;
	assign wr_shdn    = reg_wr && reg_addr == prdc_pkg::ADDR_SHDN;
	assign wr_irq_en  = reg_wr && reg_addr == prdc_pkg::ADDR_IRQ_EN;
	assign wr_irq_clr = reg_wr && reg_addr == prdc_pkg::ADDR_IRQ_CLR;

	// Level-based source, combinational so the pins are forced without waiting for a clock
	assign shdn_level = (src[prdc_pkg::SRC_CMP1_BIT] & cmp1_out)
		| (src[prdc_pkg::SRC_CMP2_BIT] & cmp2_out)
		| (src[prdc_pkg::SRC_INT_BIT] & ~int_pin_n);

	assign hw_clear = ctrl_r[prdc_pkg::CTRL_RESTART_BIT] && shdn_r[prdc_pkg::SHDN_EVENT_BIT] && !shdn_level;
	assign halt_req = shdn_level || shdn_r[prdc_pkg::SHDN_EVENT_BIT];

	// Leave the halt only on a period boundary, once the level and the flag are both gone
	assign resume = state_r == ST_HALT && !halt_req && period_start;

	// Every bit of the byte is implemented, so no write mask is needed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_r <= prdc_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= reg_wdata;
		end
	end

	// The level outranks software, so a write can never release a live shutdown
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shdn_r <= prdc_pkg::SHDN_RESET;
		end else begin
			if (wr_shdn) begin
				shdn_r[prdc_pkg::SHDN_SRC_MSB:0] <= reg_wdata[prdc_pkg::SHDN_SRC_MSB:0];
			end
			if (shdn_level) begin
				shdn_r[prdc_pkg::SHDN_EVENT_BIT] <= 1'b1;
			end else if (wr_shdn) begin
				shdn_r[prdc_pkg::SHDN_EVENT_BIT] <= reg_wdata[prdc_pkg::SHDN_EVENT_BIT];
			end else if (hw_clear) begin
				shdn_r[prdc_pkg::SHDN_EVENT_BIT] <= 1'b0;
			end
		end
	end

	// Restart waits for a period boundary so no truncated pulse reaches the bridge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_RUN;
		end else begin
			case (state_r)
				ST_RUN: begin
					if (halt_req) begin
						state_r <= ST_HALT;
					end
				end
				ST_HALT: begin
					if (resume) begin
						state_r <= ST_RUN;
					end
				end
				default: state_r <= ST_HALT;
			endcase
		end
	end

	// The level term needs no clock, so a live source forces the pins in the same cycle
	assign halted = halt_req || state_r != ST_RUN;

	// Both legs share one count; gating by the halt also restarts the count after a resume
	assign db_count = ctrl_r[prdc_pkg::CTRL_COUNT_MSB:prdc_pkg::CTRL_COUNT_LSB];
	assign pwm_ac   = pwm_in & ~halted;
	assign pwm_bd   = ~pwm_in & ~halted;

	prdc_dead_band #(.WIDTH(COUNT_W)) u_db_ac (
		.ref_clk (ref_clk),
		.rst     (rst),
		.count   (db_count),
		.sig_in  (pwm_ac),
		.sig_out (db_ac)
	);

	prdc_dead_band #(.WIDTH(COUNT_W)) u_db_bd (
		.ref_clk (ref_clk),
		.rst     (rst),
		.count   (db_count),
		.sig_in  (pwm_bd),
		.sig_out (db_bd)
	);

	// AC pair drive: shutdown state code 1x releases the pins
	always_comb begin
		out_ac    = db_ac;
		out_ac_oe = 1'b1;
		if (halted) begin
			out_ac    = shdn_r[prdc_pkg::SHDN_AC_LSB];
			out_ac_oe = ~shdn_r[prdc_pkg::SHDN_AC_MSB];
		end
	end

	// BD pair drive, same coding
	always_comb begin
		out_bd    = db_bd;
		out_bd_oe = 1'b1;
		if (halted) begin
			out_bd    = shdn_r[prdc_pkg::SHDN_BD_LSB];
			out_bd_oe = ~shdn_r[prdc_pkg::SHDN_BD_MSB];
		end
	end

	// Events: shutdown entered, and output resumed on a boundary; set wins over clear
	assign irq_set = {resume, shdn_level && !shdn_r[prdc_pkg::SHDN_EVENT_BIT]};
	assign irq_clr = wr_irq_clr ? reg_wdata[prdc_pkg::IRQ_WIDTH-1:0] : prdc_pkg::IRQ_RESET;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_en_r <= prdc_pkg::IRQ_RESET;
		end else if (wr_irq_en) begin
			irq_en_r <= reg_wdata[prdc_pkg::IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_stat_r <= prdc_pkg::IRQ_RESET;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	// Read data stand one cycle and fall back to zero, so a stale value is never seen
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				prdc_pkg::ADDR_CTRL:     rdata_r <= ctrl_r;
				prdc_pkg::ADDR_SHDN:     rdata_r <= shdn_r;
				prdc_pkg::ADDR_IRQ_STAT: rdata_r <= {6'h00, irq_stat_r};
				prdc_pkg::ADDR_IRQ_EN:   rdata_r <= {6'h00, irq_en_r};
				default:                 rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = rdata_r;
endmodule // prdc_top

// *** common/prdc_pkg.sv ***
package prdc_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] ADDR_CTRL     = 2'h0;
	localparam logic [1:0] ADDR_SHDN     = 2'h1;
	localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
	localparam logic [1:0] ADDR_IRQ_EN   = 2'h3;
	localparam logic [1:0] ADDR_IRQ_CLR  = 2'h2;

	// Restart and dead-band control register
	localparam int         CTRL_RESTART_BIT = 7;
	localparam int         CTRL_COUNT_MSB   = 6;
	localparam int         CTRL_COUNT_LSB   = 0;
	localparam logic [7:0] CTRL_RESET       = 8'h00;

	// Shutdown control register
	localparam int         SHDN_EVENT_BIT = 7;
	localparam int         SHDN_SRC_MSB   = 6;
	localparam int         SHDN_SRC_LSB   = 4;
	localparam int         SHDN_AC_MSB    = 3;
	localparam int         SHDN_AC_LSB    = 2;
	localparam int         SHDN_BD_MSB    = 1;
	localparam int         SHDN_BD_LSB    = 0;
	localparam logic [7:0] SHDN_RESET     = 8'h00;

	// Shutdown source select bit meanings
	localparam int SRC_CMP1_BIT = 0;
	localparam int SRC_CMP2_BIT = 1;
	localparam int SRC_INT_BIT  = 2;

	// Interrupt status bits
	localparam int         IRQ_SHDN_BIT    = 0;
	localparam int         IRQ_RESTART_BIT = 1;
	localparam int         IRQ_WIDTH       = 2;
	localparam logic [1:0] IRQ_RESET       = 2'h0;

	// Dead-band count width
	localparam int COUNT_WIDTH = 7;
endpackage

// *** hdl/prdc_dead_band.sv ***
`timescale 1ns/100ps
// Delays the rising edge of one output by a count of clock cycles; falls pass at once.
module prdc_dead_band #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Control
	input  wire logic [WIDTH-1:0] count,
	// Signal
	input  wire logic             sig_in,
	output logic                  sig_out
);
	logic [WIDTH-1:0] cnt_r;
	logic             out_r;

	initial begin
		if (WIDTH < 1 || WIDTH > 16) $error("prdc_dead_band: WIDTH out of range");
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else if (!sig_in) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else if (!out_r) begin
			if (cnt_r + 1'b1 >= count) begin
				out_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// Zero count passes the rising edge straight through
	assign sig_out = sig_in & (out_r | (count == '0));
endmodule // prdc_dead_band

// *** dv/prdc_properties.sv ***
`timescale 1ns/100ps
module prdc_chk (
	// Clock, reset and register port
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins
	input wire logic       pwm_in,
	input wire logic       period_start,
	input wire logic       cmp1_out,
	input wire logic       cmp2_out,
	input wire logic       int_pin_n,
	input wire logic       out_ac,
	input wire logic       out_ac_oe,
	input wire logic       out_bd,
	input wire logic       out_bd_oe,
	input wire logic       irq
);
	logic [7:0] ctl_r, shd_r, hi_r, lo_r;
	logic       run_r, hold_r;
	wire        lvl = (shd_r[4] & cmp1_out) | (shd_r[5] & cmp2_out) | (shd_r[6] & !int_pin_n);
	wire        sd_ok = out_ac_oe == !shd_r[3] && out_bd_oe == !shd_r[1] && (shd_r[3] || out_ac == shd_r[2])
		&& (shd_r[1] || out_bd == shd_r[0]);
	// Running is trusted from reset and after a period start with the whole shutdown register zero; a write to the control or shutdown register clears it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl_r <= 8'h00;
			shd_r <= 8'h00;
			run_r <= 1'h1;
			hold_r <= 1'h0;
		end else begin
			// Forced from the level until a period start with the source gone
			if (lvl) hold_r <= 1'h1;
			else if (period_start) hold_r <= 1'h0;
			if (reg_wr && reg_addr == 2'h0) ctl_r <= reg_wdata;
			if (reg_wr && reg_addr == 2'h1) shd_r <= reg_wdata;
			if (reg_wr && !reg_addr[1]) run_r <= 1'h0;
			else if (period_start && shd_r == 8'h00) run_r <= 1'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hi_r <= 8'h00;
			lo_r <= 8'h00;
		end else begin
			hi_r <= !pwm_in ? 8'h00 : (hi_r == 8'hff ? hi_r : hi_r + 8'h01);
			lo_r <= pwm_in ? 8'h00 : (lo_r == 8'hff ? lo_r : lo_r + 8'h01);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	rd_ctrl_a:
	assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata == ctl_r) else $error("ctrl readback");
	rd_idle_a:
	assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata not idle");
	rsvd_zero_a:
	assert property (reg_rd && reg_addr[1] |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
	db_ac_a:
	assert property (run_r |-> out_ac_oe && out_ac == (pwm_in && hi_r >= {1'h0, ctl_r[6:0]})) else $error("ac delay");
	db_bd_a:
	assert property (run_r |-> out_bd_oe && out_bd == (!pwm_in && lo_r >= {1'h0, ctl_r[6:0]})) else $error("bd delay");
	force_a:
	assert property (lvl |-> sd_ok) else $error("not forced");
	hold_a:
	assert property (hold_r && !period_start |-> sd_ok) else $error("early resume");
	rst_a:
	assert property (disable iff (1'h0) rst |=> !irq && reg_rdata == 8'h00) else $error("reset state");
	cover property (run_r && $rose(out_ac) && ctl_r[6:0] != 7'h00);
	cover property (lvl);
	cover property ($fell(irq));
endmodule // prdc_chk
bind prdc_top prdc_chk u_chk (.*);

// *** dv/prdc_gate_model.sv ***
`timescale 1ns/100ps
module prdc_gate_model (
	// Bridge gate inputs
	input wire logic ref_clk,
	input wire logic out_ac,
	input wire logic out_ac_oe,
	input wire logic out_bd,
	input wire logic out_bd_oe,
	// Sticky shoot-through flag
	output logic     shoot_r
);
	// Gates are pulled down, so an undriven pin leaves its switch off
	initial shoot_r = 1'h0;
	always @(posedge ref_clk)
		if (out_ac_oe && out_ac && out_bd_oe && out_bd) shoot_r <= 1'h1;
endmodule // prdc_gate_model

// *** dv/test_pwm_restart_deadband_control.sv ***
`timescale 1ns/100ps
module test_pwm_restart_deadband_control;
	logic       ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pwm_in = 1'h0, period_start = 1'h0;
	logic       cmp1_out = 1'h0, cmp2_out = 1'h0, int_pin_n = 1'h1;
	logic       out_ac, out_ac_oe, out_bd, out_bd_oe, irq, shoot_r;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	int         num_errors = 0, cmp_count = 0;
	always #20 ref_clk = ~ref_clk;
	prdc_top dut (.*);
	prdc_gate_model u_gate (.*);
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Each task starts and ends on a rising edge; the spare cycle avoids re-driving a strobe
	task automatic wr(logic [1:0] a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rd(logic [1:0] a, logic [7:0] e, string n);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(negedge ref_clk);
		chk(n, e, reg_rdata);
		@(posedge ref_clk);
	endtask
	// Tri-stated outputs compare as zero
	task automatic pins(string n, logic [4:0] e);
		@(negedge ref_clk);
		chk(n, {3'h0, e}, {3'h0, irq, out_ac_oe, out_ac & out_ac_oe, out_bd_oe, out_bd & out_bd_oe});
		@(posedge ref_clk);
	endtask
	task automatic pulse;
		period_start <= 1'h1;
		@(posedge ref_clk);
		period_start <= 1'h0;
		repeat (4) @(posedge ref_clk);
	endtask
	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		rd(2'h0, 8'h00, "ctrl");
		rd(2'h1, 8'h00, "shdn");
		wr(2'h0, 8'hff);
		rd(2'h0, 8'hff, "ctrl");
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h03, "irq_en");
		for (int c = 0; c < 4; c += 3) begin
			wr(2'h0, 8'(c));
			pwm_in <= 1'h1;
			@(posedge ref_clk);
			pwm_in <= 1'h0;
			pulse();
			pwm_in <= 1'h1;
			for (int k = 0; k < 5; k++) pins("rise", {2'h1, k >= c, 2'h2});
			pwm_in <= 1'h0;
			for (int k = 0; k < 5; k++) pins("fall", {3'h2, 1'h1, k >= c});
		end
		wr(2'h0, 8'h80);
		wr(2'h1, 8'h14);
		cmp1_out <= 1'h1;
		pins("shut", 5'h0e);
		rd(2'h1, 8'h94, "event");
		wr(2'h1, 8'h14);
		rd(2'h1, 8'h94, "event");
		pins("irq", 5'h1e);
		wr(2'h3, 8'h00);
		pins("mask", 5'h0e);
		wr(2'h3, 8'h03);
		cmp1_out <= 1'h0;
		repeat (3) @(posedge ref_clk);
		rd(2'h1, 8'h14, "auto");
		pins("halt", 5'h1e);
		pulse();
		pins("run", 5'h1b);
		rd(2'h2, 8'h03, "irq_st");
		wr(2'h2, 8'h03);
		pins("clr", 5'h0b);
		wr(2'h0, 8'h00);
		wr(2'h1, 8'h4a);
		int_pin_n <= 1'h0;
		pins("shut", 5'h00);
		int_pin_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rd(2'h1, 8'hca, "event");
		pins("hold", 5'h10);
		wr(2'h1, 8'h4a);
		pulse();
		pins("run", 5'h1b);
		wr(2'h1, 8'h24);
		cmp2_out <= 1'h1;
		pins("shut2", 5'h1e);
		cmp2_out <= 1'h0;
		chk("shoot", 8'h00, shoot_r);
		test_done();
	end
endmodule // test_pwm_restart_deadband_control
